// file: stop_wake_pkg.sv
// Purpose: Shared constants and types for the stop-mode wakeup controller
// Assumes: 200 MHz aclk, AXI4-Lite register access with 8-bit byte addresses
// Notes:   All timing counts derive from the nanosecond figures below
package stop_wake_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_SYSCTL1   = 8'h00;
   localparam logic [7:0] OFS_WUCTL     = 8'h04;
   localparam logic [7:0] OFS_WUCNT     = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0c;
   localparam logic [7:0] OFS_RESUME_PC = 8'h10;

   // system_control_one fields
   localparam int STOP_BIT     = 7;
   localparam int REL_MODE_BIT = 6;
   localparam int HOLD_EN_BIT  = 5;
   // warmup_control_reg fields
   localparam int WUSEL_BIT  = 0;
   localparam int KEYLVL_BIT = 1;
   // Status fields
   localparam int ST_STOPPED_BIT = 0;
   localparam int ST_WARMING_BIT = 1;
   localparam int ST_PIN_BIT     = 2;
   localparam int ST_IRQ5_BIT    = 3;
   localparam int ST_SINGLE_BIT  = 4;

   // Reset values and resume address offset
   localparam logic [1:0] SYSCTL1_RST = 2'h0;
   localparam logic [1:0] WUCTL_RST   = 2'h0;
   localparam logic [7:0] WUCNT_RST   = 8'h01;
   localparam logic [15:0] PC_RST     = 16'h0000;
   localparam logic [15:0] PC_SKIP    = 16'h0002;

   // Timing
   localparam int CLK_NS      = 5;
   localparam int MCYCLE_NS   = 20;
   localparam int HF_UNIT_NS  = 16000;
   localparam int LF_UNIT_NS  = 1953000;
   localparam int MCYCLE_CYC  = (MCYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HF_UNIT_CYC = HF_UNIT_NS / CLK_NS;
   localparam int LF_UNIT_CYC = LF_UNIT_NS / CLK_NS;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_STOP    = 2'b01,
      ST_WARM    = 2'b11,
      ST_RSTWARM = 2'b10
   } mode_state_t;

   typedef struct packed {
      logic rel_mode;
      logic hold_en;
   } sysctl_t;

   typedef struct packed {
      logic key_level;
      logic clk_sel;
   } wuctl_t;

endpackage

// file: warmup_counter.sv
// Purpose: Oscillator warm-up counter, counts unit ticks up to a target
// Assumes: tick is a one-cycle enable from the selected oscillator divider
// Notes:   A target of zero ends on the first tick
`timescale 1ns/1ps
`default_nettype none
module warmup_counter
   import stop_wake_pkg::*;
(
   // Clock and synchronous reset
   input  wire logic       aclk,
   input  wire logic       rst,
   // Control
   input  wire logic       start,
   input  wire logic       tick,
   input  wire logic [7:0] target,
   // Status
   output logic            busy,
   output logic            done
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       busy_r;

   assign cnt_nxt = cnt_r + 8'h01;
   assign busy    = busy_r;
   assign done    = busy_r && tick && (cnt_nxt >= target);

   always_ff @(posedge aclk) begin
      if (rst) begin
         cnt_r  <= 8'h00;
         busy_r <= 1'b0;
      end else if (start) begin
         cnt_r  <= 8'h00;
         busy_r <= 1'b1;
      end else if (done) begin
         busy_r <= 1'b0;
      end else if (busy_r && tick) begin
         cnt_r  <= cnt_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (rst);

   property p_wu_early;
      busy_r && tick && (cnt_nxt < target) |=> busy_r;
   endproperty
   a_wu_early: assert property (p_wu_early) else $error("warm-up ended early");

endmodule
`default_nettype wire

// file: stop_wake_ctrl.sv
// Purpose: STOP mode entry, hold and release sequencing with warm-up
// Assumes: Pins synchronous to aclk; por_reset and vd_reset active high
// Notes:   Registers reached over AXI4-Lite, one aligned word each
`timescale 1ns/1ps
`default_nettype none
module stop_wake_ctrl
   import stop_wake_pkg::*;
#(
   parameter int LF_TICK_CYC = LF_UNIT_CYC
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // System resets and wake sources
   input  wire logic        por_reset,
   input  wire logic        vd_reset,
   input  wire logic        stop_pin,
   input  wire logic        keyon_pin,
   input  wire logic        vd_wake,
   // Core interface
   input  wire logic        main_clk_is_low,
   input  wire logic [15:0] cpu_pc,
   output logic             core_run,
   output logic             resume_pulse,
   output logic [15:0]      resume_pc,
   output logic [15:0]      tg_prescale,
   output logic             single_clock_run_mode,
   // Oscillators and ports
   output logic             osc_hf_en,
   output logic             osc_lf_en,
   output logic             port_drive_en,
   output logic             port_one_bit_one,
   output logic             external_irq_five
);

   logic        sys_rst;
   mode_state_t state_r;
   sysctl_t     ctl_r;
   wuctl_t      wuctl_r;
   logic [7:0]  wu_target_r;
   logic        entry_low_r;
   logic [2:0]  guard_cnt_r;
   logic        pin_d_r;
   logic        pin_rise;
   logic        irq5_r;
   logic        rst_pend_r;
   logic [15:0] resume_pc_r;
   logic [15:0] tg_div_r;
   logic        resume_r;
   logic        single_r;
   logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r, rdata_r, rd_data;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r, rd_resp;
   logic        wr_do, wr_ok, stop_req, entry_ok, release_ev, key_hit;
   logic        sel_low, wu_start, wu_done, warming;
   logic [1:0]  unit_tick;

   assign sys_rst = !aresetn || por_reset || vd_reset;

   // AXI4-Lite slave handshakes
   assign awready = !aw_full_r;
   assign wready  = !w_full_r;
   assign arready = !rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;
   assign wr_do   = aw_full_r && w_full_r && !bvalid_r;
   assign wr_ok   = (awaddr_r == OFS_SYSCTL1) || (awaddr_r == OFS_WUCTL)
                 || (awaddr_r == OFS_WUCNT) || (awaddr_r == OFS_STATUS)
                 || (awaddr_r == OFS_RESUME_PC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         if (awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= awaddr;
         end
         if (wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
         end
         if (wr_do) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      if (araddr == OFS_SYSCTL1) begin
         rd_data[STOP_BIT]  = (state_r != ST_RUN);
         rd_data[REL_MODE_BIT] = ctl_r.rel_mode;
         rd_data[HOLD_EN_BIT]  = ctl_r.hold_en;
      end else if (araddr == OFS_WUCTL) begin
         rd_data[WUSEL_BIT]  = wuctl_r.clk_sel;
         rd_data[KEYLVL_BIT] = wuctl_r.key_level;
      end else if (araddr == OFS_WUCNT) begin
         rd_data[7:0] = wu_target_r;
      end else if (araddr == OFS_STATUS) begin
         rd_data[ST_STOPPED_BIT] = (state_r == ST_STOP);
         rd_data[ST_WARMING_BIT] = warming;
         rd_data[ST_PIN_BIT]     = stop_pin;
         rd_data[ST_IRQ5_BIT]    = irq5_r;
         rd_data[ST_SINGLE_BIT]  = single_r;
      end else if (araddr == OFS_RESUME_PC) begin
         rd_data[15:0] = resume_pc_r;
      end else begin
         rd_resp = RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_data;
         rresp_r  <= rd_resp;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Entry request decode
   assign stop_req = wr_do && (awaddr_r == OFS_SYSCTL1) && wstrb_r[0]
                  && wdata_r[STOP_BIT] && (state_r == ST_RUN);
   assign entry_ok = stop_req && !(wdata_r[REL_MODE_BIT] && stop_pin);

   // Control registers, frozen outside run
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         ctl_r       <= SYSCTL1_RST;
         wuctl_r     <= WUCTL_RST;
         wu_target_r <= WUCNT_RST;
      end else if (wr_do && wstrb_r[0] && (state_r == ST_RUN)) begin
         if (awaddr_r == OFS_SYSCTL1) begin
            ctl_r.rel_mode <= wdata_r[REL_MODE_BIT];
            ctl_r.hold_en  <= wdata_r[HOLD_EN_BIT];
         end else if (awaddr_r == OFS_WUCTL) begin
            wuctl_r.clk_sel   <= wdata_r[WUSEL_BIT];
            wuctl_r.key_level <= wdata_r[KEYLVL_BIT];
         end else if (awaddr_r == OFS_WUCNT) begin
            wu_target_r <= wdata_r[7:0];
         end
      end
   end

   // Stop pin edge, shared port and interrupt latch
   assign pin_rise         = stop_pin && !pin_d_r;
   assign port_one_bit_one = stop_pin;
   assign external_irq_five = irq5_r;

   always_ff @(posedge aclk) begin
      // Tracks the pin through reset, so no false edge follows it
      pin_d_r <= stop_pin;
      if (sys_rst) begin
         irq5_r <= 1'b0;
      end else begin
         if (pin_rise) begin
            irq5_r <= 1'b1;
         end else if (wr_do && (awaddr_r == OFS_STATUS) && wstrb_r[0]
                      && wdata_r[ST_IRQ5_BIT]) begin
            irq5_r <= 1'b0;
         end
      end
   end

   // Post-entry guard of one machine cycle
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         guard_cnt_r <= 3'h0;
      end else if (entry_ok) begin
         guard_cnt_r <= 3'(MCYCLE_CYC);
      end else if (guard_cnt_r != 3'h0) begin
         guard_cnt_r <= guard_cnt_r - 3'h1;
      end
   end

   assign key_hit    = (keyon_pin == wuctl_r.key_level);
   assign release_ev = (ctl_r.rel_mode ? stop_pin : (pin_rise && guard_cnt_r == 3'h0))
                    || key_hit || (vd_wake && guard_cnt_r == 3'h0);

   // Mode sequencer
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         state_r <= ST_RSTWARM;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (entry_ok) begin
                  state_r <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (release_ev) begin
                  state_r <= ST_WARM;
               end
            end
            ST_WARM: begin
               if (wu_done) begin
                  state_r <= ST_RUN;
               end
            end
            default: begin
               if (wu_done) begin
                  state_r <= ST_RUN;
               end
            end
         endcase
      end
   end

   // Entry snapshot: clock source and resume address
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         entry_low_r <= 1'b0;
         resume_pc_r <= PC_RST;
      end else if (entry_ok) begin
         entry_low_r <= main_clk_is_low;
         resume_pc_r <= cpu_pc + PC_SKIP;
      end
   end

   // Reset warm-up kick
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         rst_pend_r <= 1'b1;
      end else begin
         rst_pend_r <= 1'b0;
      end
   end

   // Unit tick dividers: hf at index 0, lf at index 1
   assign warming = (state_r == ST_WARM) || (state_r == ST_RSTWARM);
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_div
         localparam logic [19:0] LIM = (g == 0) ? 20'(HF_UNIT_CYC - 1) : 20'(LF_TICK_CYC - 1);
         logic [19:0] div_r;
         assign unit_tick[g] = warming && (div_r == LIM);
         always_ff @(posedge aclk) begin
            if (sys_rst || !warming || unit_tick[g]) begin
               div_r <= 20'h00000;
            end else begin
               div_r <= div_r + 20'h00001;
            end
         end
      end
   endgenerate

   assign sel_low  = (state_r == ST_WARM) ? entry_low_r : wuctl_r.clk_sel;
   assign wu_start = rst_pend_r || ((state_r == ST_STOP) && release_ev);

   warmup_counter u_wu (
      .aclk   (aclk),
      .rst    (sys_rst),
      .start  (wu_start),
      .tick   (sel_low ? unit_tick[1] : unit_tick[0]),
      .target (wu_target_r),
      .busy   (),
      .done   (wu_done)
   );

   // Timing generator prescaler, resume and mode flags
   always_ff @(posedge aclk) begin
      if (sys_rst) begin
         tg_div_r <= 16'h0000;
         resume_r <= 1'b0;
         single_r <= 1'b0;
      end else begin
         resume_r <= (state_r == ST_WARM) && wu_done;
         if (entry_ok || wu_done) begin
            tg_div_r <= 16'h0000;
         end else if (state_r == ST_RUN) begin
            tg_div_r <= tg_div_r + 16'h0001;
         end
         if ((state_r == ST_RSTWARM) && wu_done) begin
            single_r <= 1'b1;
         end
      end
   end

   assign core_run              = (state_r == ST_RUN);
   assign resume_pulse          = resume_r;
   assign resume_pc             = resume_pc_r;
   assign tg_prescale           = tg_div_r;
   assign single_clock_run_mode = single_r;
   assign osc_hf_en    = (state_r != ST_STOP) && !((state_r == ST_WARM) && entry_low_r);
   assign osc_lf_en    = (state_r != ST_STOP) && !((state_r == ST_WARM) && !entry_low_r);
   assign port_drive_en = core_run || ctl_r.hold_en;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (sys_rst);

   property p_entry;
      entry_ok |=> state_r == ST_STOP ##0 core_run == 1'b0;
   endproperty
   a_entry: assert property (p_entry) else $error("stop write did not enter stop");
   property p_osc_off;
      state_r == ST_STOP |-> !osc_hf_en && !osc_lf_en && !core_run;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator or core active in stop");
   property p_hold;
      state_r != ST_RUN && $past(state_r) != ST_RUN |-> $stable(ctl_r) && $stable(wu_target_r);
   endproperty
   a_hold: assert property (p_hold) else $error("control state changed during stop");
   property p_tg_clear;
      entry_ok |=> tg_prescale == 16'h0000 ##1 tg_prescale == 16'h0000;
   endproperty
   a_tg_clear: assert property (p_tg_clear) else $error("prescaler not cleared at entry");
   property p_pc;
      entry_ok |=> resume_pc == 16'($past(cpu_pc) + PC_SKIP);
   endproperty
   a_pc: assert property (p_pc) else $error("held address wrong");
   property p_lvl_reject;
      stop_req && wdata_r[REL_MODE_BIT] && stop_pin |=> state_r == ST_RUN;
   endproperty
   a_lvl_reject: assert property (p_lvl_reject) else $error("level entry with pin high");
   property p_edge_entry;
      stop_req && !wdata_r[REL_MODE_BIT] |=> state_r == ST_STOP;
   endproperty
   a_edge_entry: assert property (p_edge_entry) else $error("edge mode entry refused");
   property p_guard;
      state_r == ST_STOP && guard_cnt_r != 3'h0 && !ctl_r.rel_mode && !key_hit
         |=> state_r == ST_STOP;
   endproperty
   a_guard: assert property (p_guard) else $error("released inside guard cycle");
   property p_level_rel;
      state_r == ST_STOP && ctl_r.rel_mode && stop_pin |=> state_r == ST_WARM;
   endproperty
   a_level_rel: assert property (p_level_rel) else $error("level release missed");
   property p_edge_rel;
      state_r == ST_STOP && !ctl_r.rel_mode && pin_rise && guard_cnt_r == 3'h0
         |=> state_r == ST_WARM;
   endproperty
   a_edge_rel: assert property (p_edge_rel) else $error("edge release missed");
   property p_key_rel;
      state_r == ST_STOP && key_hit |=> state_r == ST_WARM;
   endproperty
   a_key_rel: assert property (p_key_rel) else $error("key-on release missed");
   property p_warm_stay;
      state_r == ST_WARM && !wu_done |=> state_r == ST_WARM;
   endproperty
   a_warm_stay: assert property (p_warm_stay) else $error("left warm-up early");
   property p_resume;
      state_r == ST_WARM && wu_done |=> resume_pulse && core_run && tg_prescale == 16'h0000;
   endproperty
   a_resume: assert property (p_resume) else $error("resume after warm-up wrong");
   property p_irq5;
      pin_rise |=> irq5_r;
   endproperty
   a_irq5: assert property (p_irq5) else $error("stop pin edge not latched");
   property p_src;
      state_r == ST_WARM && wu_done |-> unit_tick[entry_low_r];
   endproperty
   a_src: assert property (p_src) else $error("warm-up clock not entry clock");
   property p_rst_warm;
      state_r == ST_RSTWARM && wu_done |=> single_clock_run_mode && core_run;
   endproperty
   a_rst_warm: assert property (p_rst_warm) else $error("reset warm-up exit wrong");

   c_entry: cover property (entry_ok);
   c_edge: cover property (state_r == ST_STOP && pin_rise ##1 state_r == ST_WARM);
   c_key: cover property (state_r == ST_STOP && key_hit ##1 state_r == ST_WARM);
   c_resume: cover property (resume_pulse);

endmodule
`default_nettype wire

// file: wake_src_model.sv
// Purpose: Far-side wake sources: stop pin, key-on pin, voltage detector
// Assumes: Levels change only just after a rising aclk edge
// Notes:   Held levels stand until the bench asks for a new one
`timescale 1ns/1ps
`default_nettype none
module wake_src_model (
   // Clock
   input  wire logic aclk,
   // Wake lines
   output logic      stop_pin,
   output logic      keyon_pin,
   output logic      vd_wake
);
   initial begin
      stop_pin  = 1'b0;
      keyon_pin = 1'b0;
      vd_wake   = 1'b0;
   end

   // Set one line after dl edges, dl of one or more
   task automatic drive(input int w, input logic v, input int dl);
      repeat (dl) @(posedge aclk);
      case (w)
         0: stop_pin <= v;
         1: keyon_pin <= v;
         default: vd_wake <= v;
      endcase
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for stop_wake_ctrl
// Assumes: wake_src_model drives the wake pins
// Notes:   Short LF tick; warm-up target zero gives one tick
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import stop_wake_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        por_reset, vd_reset, main_clk_is_low, stop_pin, keyon_pin, vd_wake;
   logic        awready, wready, bvalid, arready, rvalid, core_run, resume_pulse;
   logic        single_clock_run_mode, osc_hf_en, osc_lf_en, port_drive_en;
   logic        port_one_bit_one, external_irq_five;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] cpu_pc, resume_pc, tg_prescale, pc;
   int          num_errors, compares, cycles, n;

   stop_wake_ctrl #(.LF_TICK_CYC(8)) i_stop_wake_ctrl (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .por_reset, .vd_reset,
      .stop_pin, .keyon_pin, .vd_wake, .main_clk_is_low, .cpu_pc, .core_run,
      .resume_pulse, .resume_pc, .tg_prescale, .single_clock_run_mode, .osc_hf_en,
      .osc_lf_en, .port_drive_en, .port_one_bit_one, .external_irq_five);
   wake_src_model i_wake_src_model (.aclk, .stop_pin, .keyon_pin, .vd_wake);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic end_of_test;
      $display("Counts: compares=%0d errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      r = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask

   // Wait for resume pulse or core running, bounded
   task automatic wt(input bit run, input int lim);
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while ((run ? core_run : resume_pulse) !== 1'b1 && n < lim);
      chk(n < lim, 1);
   endtask

   task automatic pin(input int w, input logic v, input int dl);
      i_wake_src_model.drive(w, v, dl);
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, por_reset, vd_reset} = '0;
      {main_clk_is_low, awaddr, araddr, wdata, cpu_pc} = '0;
      wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      void'($urandom(62643));
      wt(1, 4000);
      chk(single_clock_run_mode, 1);
      rd(OFS_WUCNT);
      chk(d[7:0], 8'h01);
      rd(8'h40);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h40, 32'h0);
      chk(r, RESP_SLVERR);
      wr(OFS_WUCNT, 32'h0);
      wr(OFS_WUCTL, 32'h3);
      $display("Test reset done");
      for (int i = 0; i < 3; i++) begin
         pc = 16'($urandom());
         @(posedge aclk);
         cpu_pc <= pc;
         wr(OFS_SYSCTL1, 32'h80);
         @(negedge aclk);
         chk(core_run, 0);
         chk({osc_hf_en, osc_lf_en}, 0);
         chk(port_drive_en, 0);
         chk(tg_prescale, 0);
         chk(resume_pc, pc + 16'h2);
         pin(0, 1'b1, 1);
         repeat (10) @(negedge aclk);
         chk(core_run, 0);
         rd(OFS_STATUS);
         chk(d[ST_STOPPED_BIT], 1);
         rd(OFS_RESUME_PC);
         chk(d[15:0], pc + 16'h2);
         pin(0, 1'b0, 1);
         pin(0, 1'b1, 1 + $urandom_range(20));
         repeat (3) @(negedge aclk);
         chk({osc_hf_en, osc_lf_en}, 2'b10);
         wt(0, 4000);
         chk(resume_pc, pc + 16'h2);
         chk(tg_prescale < 2, 1);
      end
      $display("Test edge release done");
      wr(OFS_SYSCTL1, 32'he0);
      @(negedge aclk);
      chk(core_run, 1);
      pin(0, 1'b0, 1);
      wr(OFS_SYSCTL1, 32'he0);
      @(negedge aclk);
      chk({core_run, port_drive_en}, 2'b01);
      pin(0, 1'b1, 1);
      wt(0, 4000);
      $display("Test level release done");
      wr(OFS_SYSCTL1, 32'h80);
      @(negedge aclk);
      chk(core_run, 0);
      pin(1, 1'b1, 8);
      pin(1, 1'b0, 4);
      wt(0, 4000);
      $display("Test key release done");
      @(posedge aclk);
      main_clk_is_low <= 1'b1;
      wr(OFS_SYSCTL1, 32'h80);
      pin(2, 1'b1, 8);
      repeat (2) @(negedge aclk);
      chk({osc_hf_en, osc_lf_en}, 2'b01);
      pin(2, 1'b0, 1);
      wt(0, 100);
      $display("Test detector release done");
      pin(0, 1'b0, 1);
      wr(OFS_STATUS, 32'h8);
      rd(OFS_STATUS);
      chk(d[ST_IRQ5_BIT], 0);
      pin(0, 1'b1, 1);
      repeat (2) @(negedge aclk);
      chk({external_irq_five, port_one_bit_one}, 2'b11);
      $display("Test irq latch done");
      for (int k = 0; k < 2; k++) begin
         wr(OFS_WUCTL, 32'h2);
         wr(OFS_SYSCTL1, 32'h80);
         por_reset <= (k == 0);
         vd_reset <= (k == 1);
         repeat (2) @(posedge aclk);
         {por_reset, vd_reset} <= 2'b00;
         @(negedge aclk);
         chk(core_run, 0);
         chk(single_clock_run_mode, 0);
         wt(1, 4000);
         chk(single_clock_run_mode, 1);
      end
      $display("Test reset release done");
      end_of_test();
   end
endmodule
`default_nettype wire
